// ===== mcf_framer.sv
// Multi-channel capture record framer with AXI4-Lite control registers.
// Assumes capture inputs synchronous to clk_sys; the host side drains the
// 32-bit word stream, byte lane 0 being the first byte in memory.
`timescale 1ns/1ps
`include "mcf_regs.svh"

module mcf_framer
   import mcf_pkg::*;
(
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rst_n,
   // Capture descriptor
   input wire logic cap_start,
   output logic cap_ready,
   input wire logic cap_raw,
   input wire logic [9:0] cap_conn,
   input wire logic [3:0] cap_phys,
   input wire logic [63:0] cap_ts,
   input wire logic [15:0] cap_wlen,
   input wire logic [15:0] cap_len,
   input wire logic [31:0] cap_hdlc,
   input wire logic cap_fcs_err,
   input wire logic cap_abort,
   input wire logic cap_octet_err,
   input wire logic cap_lost,
   input wire logic cap_first,
   input wire logic cap_from_line,
   input wire logic cap_trunc,
   // Capture payload bytes
   input wire logic pay_valid,
   input wire logic [7:0] pay_data,
   output logic pay_ready,
   // Record word stream toward host memory
   output logic out_valid,
   output logic [31:0] out_data,
   output logic out_last,
   input wire logic out_ready,
   // Transmit record routing
   input wire logic tx_valid,
   input wire logic tx_dir,
   output logic tx_to_line,
   output logic tx_to_host,
   // AXI4-Lite slave
   input wire logic [4:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [4:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready
);

   // Network order for header fields on a lane-0-first bus
   function automatic logic [31:0] swap32(input logic [31:0] v);
      swap32 = {v[7:0], v[15:8], v[23:16], v[31:24]};
   endfunction

   function automatic logic [31:0] strb_merge(input logic [31:0] old,
      input logic [31:0] wd, input logic [3:0] st);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (st[i]) begin
            r[8*i +: 8] = wd[8*i +: 8];
         end
      end
      strb_merge = r;
   endfunction

   logic rst_meta_ff;
   logic rst_sync_ff;
   mcf_regs_t s_ff;
   mcf_regs_t nxt_s;

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         rst_meta_ff <= 1'b0;
         rst_sync_ff <= 1'b0;
      end else begin
         rst_meta_ff <= 1'b1;
         rst_sync_ff <= rst_meta_ff;
      end
   end

   always_comb begin
      logic drop;
      logic free;
      logic [15:0] pad;
      logic [31:0] cw;
      logic [7:0] fl;
      logic [31:0] merged;
      drop = 1'b0;
      free = 1'b0;
      pad = 16'h0000;
      cw = 32'h0000_0000;
      fl = 8'h00;
      merged = 32'h0000_0000;
      nxt_s = s_ff;
      // Transmit routing by direction bit
      nxt_s.tx_line = tx_valid && tx_dir;
      nxt_s.tx_host = tx_valid && !tx_dir;

      // Packets refused while busy count as overload losses; set wins
      drop = cap_start && !s_ff.crdy;
      if (drop && s_ff.lost != 16'hFFFF) begin
         nxt_s.lost = s_ff.lost + 16'h0001;
      end
      if (s_ff.ovld && out_ready) begin
         nxt_s.ovld = 1'b0;
         nxt_s.olast = 1'b0;
      end
      free = !s_ff.ovld || out_ready;
      case (s_ff.state)
         ST_IDLE: begin
            if (cap_start && s_ff.crdy) begin
               pad = 16'(cap_len + 16'h0003) & 16'hFFFC;
               if (cap_raw) begin
                  cw = {28'h0000000, cap_phys};
                  cw[`MCF_CH_SHORT] = cap_len < `MCF_RAW_MIN;
                  cw[`MCF_CH_LONG] = cap_len > `MCF_LEN_MAX;
                  cw[`MCF_CH_LOST] = cap_lost;
                  nxt_s.rtype = `MCF_TYPE_RAW;
                  nxt_s.rlen = 16'(`MCF_HDR_RAW + pad);
               end else begin
                  cw = {22'h000000, cap_conn};
                  cw[`MCF_CH_FCS] = cap_fcs_err;
                  cw[`MCF_CH_SHORT] = cap_len < `MCF_FRAME_MIN;
                  cw[`MCF_CH_LONG] = cap_len > `MCF_LEN_MAX;
                  cw[`MCF_CH_ABORT] = cap_abort;
                  cw[`MCF_CH_OCTET] = cap_octet_err;
                  cw[`MCF_CH_LOST] = cap_lost;
                  nxt_s.rtype = `MCF_TYPE_FRAME;
                  nxt_s.rlen = 16'(`MCF_HDR_FRAME + pad);
               end
               cw[`MCF_CH_FIRST] = cap_first;
               // Interface bits and bit 6 stay zero
               fl = 8'h00;
               fl[`MCF_FLG_VARY] = 1'b1;
               fl[`MCF_FLG_TRUNC] = cap_trunc;
               fl[`MCF_FLG_RXERR] = |cw[`MCF_CH_LOST:`MCF_CH_FCS];
               fl[`MCF_FLG_DPERR] = cap_lost;
               fl[`MCF_FLG_DIR] = cap_from_line;
               nxt_s.mch = cw;
               nxt_s.flags = fl;
               nxt_s.ts = cap_ts;
               nxt_s.wlen = cap_wlen;
               nxt_s.hdlc = cap_hdlc;
               nxt_s.rem = cap_len;
               nxt_s.idx = 2'h0;
               nxt_s.state = ST_TS0;
            end
         end
         ST_TS0: begin
            if (free) begin
               nxt_s.odata = s_ff.ts[31:0];
               nxt_s.ovld = 1'b1;
               nxt_s.state = ST_TS1;
            end
         end
         ST_TS1: begin
            if (free) begin
               nxt_s.odata = s_ff.ts[63:32];
               nxt_s.ovld = 1'b1;
               nxt_s.state = ST_W2;
            end
         end
         ST_W2: begin
            if (free) begin
               nxt_s.odata = swap32({s_ff.rtype, s_ff.flags, s_ff.rlen});
               nxt_s.ovld = 1'b1;
               nxt_s.state = ST_W3;
            end
         end
         ST_W3: begin
            if (free) begin
               if (s_ff.ctrl[`MCF_CTRL_COL]) begin
                  nxt_s.odata = swap32({s_ff.colour, s_ff.wlen});
               end else begin
                  nxt_s.odata = swap32({s_ff.lost, s_ff.wlen});
                  nxt_s.lost = {15'h0000, drop};
               end
               nxt_s.ovld = 1'b1;
               nxt_s.state = ST_CH;
            end
         end
         ST_CH: begin
            if (free) begin
               nxt_s.odata = swap32(s_ff.mch);
               nxt_s.ovld = 1'b1;
               if (s_ff.rtype == `MCF_TYPE_FRAME) begin
                  nxt_s.state = ST_HD;
               end else if (s_ff.rem == 16'h0000) begin
                  nxt_s.olast = 1'b1;
                  nxt_s.state = ST_IDLE;
               end else begin
                  nxt_s.state = ST_PAY;
               end
            end
         end
         ST_HD: begin
            if (free) begin
               nxt_s.odata = swap32(s_ff.hdlc);
               nxt_s.ovld = 1'b1;
               if (s_ff.rem == 16'h0000) begin
                  nxt_s.olast = 1'b1;
                  nxt_s.state = ST_IDLE;
               end else begin
                  nxt_s.state = ST_PAY;
               end
            end
         end
         ST_PAY: begin
            if (s_ff.prdy && pay_valid) begin
               // First byte of a word clears the rest, so padding reads zero
               if (s_ff.idx == 2'h0) begin
                  nxt_s.odata = {24'h000000, pay_data};
               end else begin
                  nxt_s.odata[8*s_ff.idx +: 8] = pay_data;
               end
               nxt_s.idx = s_ff.idx + 2'h1;
               nxt_s.rem = s_ff.rem - 16'h0001;
               if (s_ff.idx == 2'h3 || s_ff.rem == 16'h0001) begin
                  nxt_s.ovld = 1'b1;
                  nxt_s.idx = 2'h0;
               end
               if (s_ff.rem == 16'h0001) begin
                  nxt_s.olast = 1'b1;
                  nxt_s.state = ST_IDLE;
               end
            end
         end
         default: begin
            nxt_s.state = ST_IDLE;
         end
      endcase
      if (nxt_s.olast && !s_ff.olast) begin
         nxt_s.recs = s_ff.recs + 16'h0001;
      end
      nxt_s.crdy = nxt_s.state == ST_IDLE && nxt_s.ctrl[`MCF_CTRL_EN];
      nxt_s.prdy = nxt_s.state == ST_PAY && !nxt_s.ovld;

      // AXI4-Lite write: address and data in either order
      if (s_ff.awready && s_axi_awvalid) begin
         nxt_s.aw_got = 1'b1;
         nxt_s.aw_addr = s_axi_awaddr;
      end
      if (s_ff.wready && s_axi_wvalid) begin
         nxt_s.w_got = 1'b1;
         nxt_s.wdata = s_axi_wdata;
         nxt_s.wstrb = s_axi_wstrb;
      end
      if (s_ff.bvalid && s_axi_bready) begin
         nxt_s.bvalid = 1'b0;
      end
      if (s_ff.aw_got && s_ff.w_got && !s_ff.bvalid) begin
         nxt_s.aw_got = 1'b0;
         nxt_s.w_got = 1'b0;
         nxt_s.bvalid = 1'b1;
         nxt_s.bresp = `MCF_RESP_OK;
         case ({s_ff.aw_addr[4:2], 2'b00})
            `MCF_OFS_CTRL: begin
               merged = strb_merge({30'h0, s_ff.ctrl}, s_ff.wdata, s_ff.wstrb);
               nxt_s.ctrl = merged[1:0];
            end
            `MCF_OFS_COLOUR: begin
               merged = strb_merge({16'h0, s_ff.colour}, s_ff.wdata, s_ff.wstrb);
               nxt_s.colour = merged[15:0];
            end
            `MCF_OFS_STATUS, `MCF_OFS_RECS, `MCF_OFS_LOST: nxt_s.bresp = `MCF_RESP_OK;
            default: begin
               nxt_s.bresp = `MCF_RESP_ERR;
            end
         endcase
      end
      nxt_s.awready = !nxt_s.aw_got && !nxt_s.bvalid;
      nxt_s.wready = !nxt_s.w_got && !nxt_s.bvalid;

      // AXI4-Lite read
      if (s_ff.rvalid && s_axi_rready) begin
         nxt_s.rvalid = 1'b0;
      end
      if (s_ff.arready && s_axi_arvalid) begin
         nxt_s.rvalid = 1'b1;
         nxt_s.rresp = `MCF_RESP_OK;
         case ({s_axi_araddr[4:2], 2'b00})
            `MCF_OFS_CTRL: nxt_s.rdata = {30'h0, s_ff.ctrl};
            `MCF_OFS_COLOUR: nxt_s.rdata = {16'h0, s_ff.colour};
            `MCF_OFS_STATUS: nxt_s.rdata = {23'h0, s_ff.state != ST_IDLE, s_ff.state};
            `MCF_OFS_RECS: nxt_s.rdata = {16'h0, s_ff.recs};
            `MCF_OFS_LOST: nxt_s.rdata = {16'h0, s_ff.lost};
            default: begin
               nxt_s.rdata = 32'h0000_0000;
               nxt_s.rresp = `MCF_RESP_ERR;
            end
         endcase
      end
      nxt_s.arready = !nxt_s.rvalid;
   end

   always_ff @(posedge clk_sys or negedge rst_sync_ff) begin
      if (!rst_sync_ff) begin
         s_ff <= '0;
         s_ff.state <= ST_IDLE;
         s_ff.ctrl <= `MCF_CTRL_RST;
         s_ff.colour <= `MCF_COLOUR_RST;
      end else begin
         s_ff <= nxt_s;
      end
   end

   assign cap_ready = s_ff.crdy;
   assign pay_ready = s_ff.prdy;
   assign out_valid = s_ff.ovld;
   assign out_data = s_ff.odata;
   assign out_last = s_ff.olast;
   assign tx_to_line = s_ff.tx_line;
   assign tx_to_host = s_ff.tx_host;
   assign s_axi_awready = s_ff.awready;
   assign s_axi_wready = s_ff.wready;
   assign s_axi_bresp = s_ff.bresp;
   assign s_axi_bvalid = s_ff.bvalid;
   assign s_axi_arready = s_ff.arready;
   assign s_axi_rdata = s_ff.rdata;
   assign s_axi_rresp = s_ff.rresp;
   assign s_axi_rvalid = s_ff.rvalid;

endmodule

// ===== mcf_framer_asserts.sv
// Checker for the record framer: stream order and header fields.
// Bound to mcf_framer; sees its ports only.
`timescale 1ns/1ps
module mcf_framer_asserts (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rst_n,
   // Capture and record stream
   input wire logic cap_start,
   input wire logic cap_ready,
   input wire logic cap_raw,
   input wire logic [63:0] cap_ts,
   input wire logic out_valid,
   input wire logic [31:0] out_data,
   input wire logic out_last,
   input wire logic out_ready,
   // Transmit routing
   input wire logic tx_valid,
   input wire logic tx_dir,
   input wire logic tx_to_line,
   input wire logic tx_to_host
);
   logic [7:0] widx_ff;
   logic [63:0] ts_ff;
   logic raw_ff;
   wire logic hdr1 = out_valid && widx_ff == 8'h01;
   wire logic hdr2 = out_valid && widx_ff == 8'h02;
   wire logic [15:0] rlen = {out_data[23:16], out_data[31:24]};

   // Word index within the current record
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         widx_ff <= 8'h00;
      end else if (out_valid && out_ready) begin
         widx_ff <= out_last ? 8'h00 : widx_ff + 8'h01;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (cap_start && cap_ready) begin
         ts_ff <= cap_ts;
         raw_ff <= cap_raw;
      end
   end

   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!rst_n);

   sequence s_take;
      cap_start && cap_ready;
   endsequence
   sequence s_ts_lo;
      ##2 out_valid && out_data == $past(cap_ts[31:0], 2);
   endsequence

   AST_TS_LO: assert property (s_take |-> s_ts_lo)
      else $error("timestamp low word wrong or late");
   AST_TS_HI: assert property (hdr1 |-> out_data == ts_ff[63:32])
      else $error("timestamp high word wrong");
   AST_BUSY: assert property (s_take |=> !cap_ready [*2])
      else $error("descriptor taken while busy");
   AST_TYPE: assert property (hdr2 |-> out_data[7:0] == (raw_ff ? 8'h06 : 8'h05))
      else $error("record type code wrong");
   AST_FLAG_IF: assert property (hdr2 |-> out_data[10:8] == 3'b100)
      else $error("interface or length mode flags wrong");
   AST_FLAG_RSV: assert property (hdr2 |-> !out_data[14])
      else $error("reserved flag set");
   AST_RLEN: assert property (hdr2 |-> rlen[1:0] == 2'b00 && rlen >= 16'h0014)
      else $error("record length out of form");
   AST_HOLD: assert property (out_valid && !out_ready |=> out_valid && $stable(out_data))
      else $error("stream word changed before taken");
   AST_TX_LINE: assert property (tx_valid && tx_dir |=> tx_to_line && !tx_to_host)
      else $error("line routing wrong");
   AST_TX_HOST: assert property (tx_valid && !tx_dir |=> tx_to_host && !tx_to_line)
      else $error("host routing wrong");
endmodule

bind mcf_framer mcf_framer_asserts u_chk (.clk_sys, .rst_n, .cap_start, .cap_ready, .cap_raw,
   .cap_ts, .out_valid, .out_data, .out_last, .out_ready, .tx_valid, .tx_dir, .tx_to_line,
   .tx_to_host);

// ===== mcf_host_mem.sv
// Host memory model: drains the record word stream into a queue.
// Assumes the framer's stream handshake; slow halves the drain rate.
`timescale 1ns/1ps
module mcf_host_mem (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rst_n,
   // Record stream
   input wire logic out_valid,
   input wire logic [31:0] out_data,
   input wire logic out_last,
   output logic out_ready,
   // Pacing
   input wire logic slow
);
   logic [32:0] got[$];

   always @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         out_ready <= 1'b0;
      end else begin
         if (out_valid && out_ready) begin
            got.push_back({out_last, out_data});
         end
         out_ready <= slow ? !out_ready : 1'b1;
      end
   end
endmodule

// ===== mcf_pkg.sv
// Types of the capture record framer: state encoding and state record.
// Assumes mcf_regs.svh on the include path.
`include "mcf_regs.svh"

package mcf_pkg;

   typedef enum logic [7:0] {
      ST_IDLE = 8'h01,
      ST_TS0 = 8'h02,
      ST_TS1 = 8'h04,
      ST_W2 = 8'h08,
      ST_W3 = 8'h10,
      ST_CH = 8'h20,
      ST_HD = 8'h40,
      ST_PAY = 8'h80
   } mcf_state_t;

   typedef struct packed {
      mcf_state_t state;
      logic crdy;
      logic prdy;
      logic ovld;
      logic olast;
      logic [31:0] odata;
      logic [1:0] idx;
      logic [63:0] ts;
      logic [15:0] wlen;
      logic [15:0] rem;
      logic [15:0] rlen;
      logic [31:0] hdlc;
      logic [31:0] mch;
      logic [7:0] flags;
      logic [7:0] rtype;
      logic [15:0] lost;
      logic [15:0] recs;
      logic [1:0] ctrl;
      logic [15:0] colour;
      logic tx_line;
      logic tx_host;
      logic aw_got;
      logic w_got;
      logic [4:0] aw_addr;
      logic [31:0] wdata;
      logic [3:0] wstrb;
      logic awready;
      logic wready;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
   } mcf_regs_t;

endpackage

// ===== mcf_regs.svh
// Constants of the capture record framer: register map, reset values,
// record codes, flag and per-channel header bit positions, size limits.
// Assumes inclusion by bare name from the package and the framer.
`ifndef MCF_REGS_SVH
`define MCF_REGS_SVH

// Register byte offsets
`define MCF_OFS_CTRL 5'h00
`define MCF_OFS_COLOUR 5'h04
`define MCF_OFS_STATUS 5'h08
`define MCF_OFS_RECS 5'h0C
`define MCF_OFS_LOST 5'h10
// Control fields and reset values
`define MCF_CTRL_EN 0
`define MCF_CTRL_COL 1
`define MCF_CTRL_RST 2'h1
`define MCF_COLOUR_RST 16'h0000
// Record type codes
`define MCF_TYPE_FRAME 8'h05
`define MCF_TYPE_RAW 8'h06
`define MCF_TYPE_CELL 8'h07
`define MCF_TYPE_RAWCH 8'h08
`define MCF_TYPE_AAL5 8'h09
`define MCF_TYPE_AAL2 8'h0C
// Flags byte bit positions
`define MCF_FLG_VARY 2
`define MCF_FLG_TRUNC 3
`define MCF_FLG_RXERR 4
`define MCF_FLG_DPERR 5
`define MCF_FLG_DIR 7
// Per-channel header bit positions
`define MCF_CH_FCS 24
`define MCF_CH_SHORT 25
`define MCF_CH_LONG 26
`define MCF_CH_ABORT 27
`define MCF_CH_OCTET 28
`define MCF_CH_LOST 29
`define MCF_CH_FIRST 30
// Header sizes in bytes, length limits and AXI response codes
`define MCF_HDR_GEN 16'h0010
`define MCF_HDR_RAW 16'h0014
`define MCF_HDR_FRAME 16'h0018
`define MCF_FRAME_MIN 16'h0005
`define MCF_RAW_MIN 16'h0006
`define MCF_LEN_MAX 16'h07FF
`define MCF_RESP_OK 2'h0
`define MCF_RESP_ERR 2'h2

`endif

// ===== tb_mcf_framer.sv
// Testbench for the record framer: records, routing and registers.
// Assumes mcf_framer and mcf_host_mem compiled first.
`timescale 1ns/1ps
module tb_mcf_framer;
   logic clk_sys = 1'b0, rst_n = 1'b0, slow = 1'b0;
   // Capture side
   logic cap_start = 1'b0, cap_raw = 1'b0, cap_fcs_err = 1'b0, cap_abort = 1'b0;
   logic cap_octet_err = 1'b0, cap_lost = 1'b0, cap_first = 1'b0, cap_from_line = 1'b0;
   logic cap_trunc = 1'b0, pay_valid = 1'b0, tx_valid = 1'b0, tx_dir = 1'b0;
   logic [9:0] cap_conn = 10'h1FF;
   logic [3:0] cap_phys = 4'hF, s_axi_wstrb = 4'hF;
   logic [63:0] cap_ts = 64'h0;
   logic [15:0] cap_wlen = 16'h0000, cap_len = 16'h0000;
   logic [31:0] cap_hdlc = 32'h0F0E0D0C, s_axi_wdata = 32'h0, s_axi_rdata, out_data;
   logic [7:0] pay_data = 8'h00;
   logic [4:0] s_axi_awaddr = 5'h00, s_axi_araddr = 5'h00;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   // Outputs
   logic cap_ready, pay_ready, out_valid, out_last, out_ready, tx_to_line, tx_to_host;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   int failures = 0, checked = 0;
   logic [32:0] exp[$];

   always #12.5 clk_sys = ~clk_sys;

   mcf_framer DUT (.*);
   mcf_host_mem HOST (.*);

   function automatic logic [31:0] sw(input logic [31:0] v);
      return {v[7:0], v[15:8], v[23:16], v[31:24]};
   endfunction

   task automatic conclude();
      $display("checked %0d failures %0d", checked, failures);
      if (failures == 0 && checked > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   task automatic chk(input string what, input logic [32:0] e, input logic [32:0] g);
      checked++;
      if (g !== e) begin
         failures++;
         $display("[FAIL] %s expected %h seen %h", what, e, g);
      end
   endtask

   task automatic tmo(input int n, input int lim);
      if (n >= lim) begin
         failures++;
         $display("[FAIL] wait expected done seen timeout");
         conclude();
      end
   endtask

   task automatic axw(input logic [4:0] a, input logic [31:0] d, input logic [1:0] r);
      int n;
      bit done;
      done = 1'b0;
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      for (n = 0; n < 50 && !done; n++) begin
         @(posedge clk_sys);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
         if (s_axi_bvalid) begin
            s_axi_bready <= 1'b0;
            done = 1'b1;
            chk("bresp", {31'h0, r}, {31'h0, s_axi_bresp});
         end
      end
      tmo(n, 50);
      // Idle edge so a following call does not re-raise bready in the same step
      @(posedge clk_sys);
   endtask

   task automatic axr(input logic [4:0] a, input logic [31:0] d, input logic [1:0] r);
      int n;
      bit done;
      done = 1'b0;
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      for (n = 0; n < 50 && !done; n++) begin
         @(posedge clk_sys);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
         if (s_axi_rvalid) begin
            s_axi_rready <= 1'b0;
            done = 1'b1;
            chk("rdata", {1'b0, d}, {1'b0, s_axi_rdata});
            chk("rresp", {31'h0, r}, {31'h0, s_axi_rresp});
         end
      end
      tmo(n, 50);
      // Idle edge so a following call does not re-raise rready in the same step
      @(posedge clk_sys);
   endtask

   // One record: set descriptor, build expected words, feed payload, compare
   task automatic rec(input logic raw, input logic [15:0] len, input logic [4:0] e,
      input logic line, input logic trunc, input logic [15:0] ctr, input bit drop);
      int n, k, hn;
      logic [15:0] rl;
      logic [31:0] ch, w;
      logic [7:0] fl;
      logic sh, lg;
      cap_raw <= raw;
      cap_len <= len;
      {cap_fcs_err, cap_abort, cap_octet_err, cap_lost, cap_first} <= e;
      cap_from_line <= line;
      cap_trunc <= trunc;
      cap_wlen <= len + 16'h0004;
      cap_ts <= {48'h887766554433, len};
      @(posedge clk_sys);
      hn = raw ? 5 : 6;
      sh = raw ? len < 16'h0006 : len < 16'h0005;
      lg = len > 16'h07FF;
      rl = (raw ? 16'h0014 : 16'h0018) + ((len + 16'h0003) & 16'hFFFC);
      if (raw) ch = {1'b0, cap_first, cap_lost, 2'b00, lg, sh, 21'h0, cap_phys};
      else ch = {1'b0, cap_first, cap_lost, cap_octet_err, cap_abort, lg, sh, cap_fcs_err,
         14'h0, cap_conn};
      fl = {line, 1'b0, cap_lost, |ch[29:24], trunc, 1'b1, 2'b00};
      exp = {};
      exp.push_back({1'b0, cap_ts[31:0]});
      exp.push_back({1'b0, cap_ts[63:32]});
      exp.push_back({1'b0, sw({raw ? 8'h06 : 8'h05, fl, rl})});
      exp.push_back({1'b0, sw({ctr, cap_wlen})});
      exp.push_back({1'b0, sw(ch)});
      if (!raw) exp.push_back({1'b0, sw(cap_hdlc)});
      for (k = 0; k < len; k += 4) begin
         w = 32'h0;
         for (n = 0; n < 4 && k + n < len; n++) w[8*n +: 8] = 8'hA0 + 8'(k + n);
         exp.push_back({1'b0, w});
      end
      exp[exp.size() - 1][32] = 1'b1;
      for (n = 0; n < 400 && !cap_ready; n++) @(posedge clk_sys);
      tmo(n, 400);
      cap_start <= 1'b1;
      @(posedge clk_sys);
      cap_start <= 1'b0;
      if (drop) begin
         for (n = 0; n < 400 && HOST.got.size() < hn; n++) @(posedge clk_sys);
         tmo(n, 400);
         cap_start <= 1'b1;
         @(posedge clk_sys);
         cap_start <= 1'b0;
      end
      k = 0;
      pay_valid <= len != 16'h0000;
      pay_data <= 8'hA0;
      for (n = 0; n < 400 && k < len; n++) begin
         @(posedge clk_sys);
         if (pay_ready) begin
            k++;
            pay_valid <= k < len;
            pay_data <= 8'hA0 + 8'(k);
         end
      end
      tmo(n, 400);
      for (n = 0; n < 400 && HOST.got.size() < exp.size(); n++) @(posedge clk_sys);
      tmo(n, 400);
      chk("words", 33'(exp.size()), 33'(HOST.got.size()));
      foreach (exp[i]) chk("word", exp[i], HOST.got[i]);
      HOST.got.delete();
   endtask

   initial begin
      repeat (3) @(posedge clk_sys);
      rst_n <= 1'b1;
      repeat (4) @(posedge clk_sys);
      chk("cap_ready", 33'h1, {32'h0, cap_ready});
      axr(5'h00, 32'h1, 2'h0);
      axr(5'h14, 32'h0, 2'h2);
      axw(5'h14, 32'hFFFF, 2'h2);
      axw(5'h04, 32'h1234, 2'h0);
      axr(5'h04, 32'h1234, 2'h0);
      for (int d = 0; d < 2; d++) begin
         tx_valid <= 1'b1;
         tx_dir <= d[0];
         @(posedge clk_sys);
         tx_valid <= 1'b0;
         @(posedge clk_sys);
         chk("tx_route", {31'h0, d[0], !d[0]}, {31'h0, tx_to_line, tx_to_host});
      end
      slow <= 1'b1;
      rec(1'b0, 16'h0005, 5'b10001, 1'b1, 1'b0, 16'h0000, 1'b0);
      slow <= 1'b0;
      rec(1'b1, 16'h0005, 5'b00010, 1'b0, 1'b1, 16'h0000, 1'b1);
      axr(5'h10, 32'h1, 2'h0);
      rec(1'b0, 16'h0004, 5'b01100, 1'b0, 1'b0, 16'h0001, 1'b0);
      rec(1'b1, 16'h0006, 5'b00000, 1'b1, 1'b0, 16'h0000, 1'b0);
      axw(5'h00, 32'h3, 2'h0);
      rec(1'b0, 16'h0000, 5'b00000, 1'b1, 1'b0, 16'h1234, 1'b0);
      axw(5'h08, 32'h0, 2'h0);
      axr(5'h08, 32'h1, 2'h0);
      axr(5'h0C, 32'h5, 2'h0);
      conclude();
   end
endmodule
